/* verilog/nmcd_core.sv */
`timescale 1ns/100ps
`include "nmcd_cfg.svh"
// Operation
// RULE1: program store is 1024 bytes, viewed as 16 pages of 64 words
// RULE2: 10-bit fetch pointer selects exactly one program word
// RULE3: fetch pointer updates every cycle, plus one unless control transfers
// RULE4: three 10-bit save levels form a last-in first-out return stack
// RULE5: data store is 4 rows of 16 four-bit digits
// RULE6: pointer upper 2 bits pick row, lower 4 bits pick digit
// RULE7: addressed digit loads, stores, swaps with result; moves with port store, pins
// RULE8: direct load and swap use operand address instead of data pointer
// RULE9: digit select feeds output nibble register driving four pins
// RULE10: result register loads pointer halves and swaps with serial register
// RULE11: result moves nibbles of port store and reads nibbles of octet port
// RULE12: 4-bit adder writes result register and carry into overflow bit
// RULE13: overflow bit steers shift clock pin directly or as sync clock
// RULE14: mask option turns three probes into read, select, write strobes
// RULE15: bidirectional nibble drives four pins, bit 0 optionally host ready
// RULE16: port store loaded from digit, result or constant; drives octet port
// RULE17: host write strobe captures octet pins into port store
// RULE18: octet pins read into result register or addressed digit
// RULE19: instruction cycle is oscillator divided by 16 or by 8
// RULE20: cycle time 4 to 10 us; RC mode divides by 4
// RULE21: feature bit 2 enables octet drivers, clear means high impedance
// RULE22: serial swap copies overflow to clock latch; shift mode ANDs with clock, here shift bit set passes latch directly
// RULE23: reset held three cycles clears pointer and registers, not data store
// RULE24: host read low drives port store; select gates strobes; write clears ready
// RULE25: sequential fetch pointer wraps from last address to zero
// RULE26: call pushes into top level shifting down, pop reverses, deepest lost
module nmcd_core
   import nmcd_pkg::*;
#(
   parameter int PC_W = `NMCD_PC_W,
   parameter int ROM_WORDS = `NMCD_ROM_WORDS
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic reset_in_n,
   input wire nmcd_div_t div_mode,
   input wire logic host_bus_opt,
   input wire logic ready_opt,
   input wire logic op_valid,
   input wire nmcd_op_t op_code,
   input wire logic [7:0] op_operand,
   input wire logic [PC_W-1:0] op_target,
   input wire logic rom_we,
   input wire logic [PC_W-1:0] rom_waddr,
   input wire logic [7:0] rom_wdata,
   input wire logic [3:0] serial_in_word,
   input wire logic [3:0] four_probes,
   input wire logic [7:0] octet_in,
   input wire logic [3:0] bidir_in,
   output logic [7:0] rom_data,
   output logic [PC_W-1:0] fetch_pointer,
   output logic [PC_W-1:0] stack_top,
   output logic [PC_W-1:0] stack_mid,
   output logic [PC_W-1:0] stack_bottom,
   output logic [3:0] acc_out,
   output logic carry_out,
   output logic [1:0] row_select,
   output logic [3:0] digit_select,
   output logic [3:0] nibble_out,
   output logic [3:0] bidir_out,
   output logic [3:0] feature_out,
   output logic [3:0] serial_out_word,
   output logic serial_load,
   output logic [7:0] octet_out,
   output logic octet_oe,
   output logic shift_clock_pin,
   output logic instr_tick,
   output logic [3:0] probes_out
);
   initial begin
      if (PC_W != `NMCD_PC_W || ROM_WORDS != (1 << PC_W)) $error("nmcd_core: unsupported size");
   end
   // synchronisers for pins
   logic [1:0] rst_sync_reg;
   logic [3:0] probe_s1_reg, probe_s2_reg;
   logic [7:0] octet_s1_reg, octet_s2_reg;
   logic [3:0] bidir_s1_reg, bidir_s2_reg;
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rst_sync_reg <= 2'h3;
         probe_s1_reg <= 4'hF;
         probe_s2_reg <= 4'hF;
         octet_s1_reg <= 8'h00;
         octet_s2_reg <= 8'h00;
         bidir_s1_reg <= 4'h0;
         bidir_s2_reg <= 4'h0;
         probes_out <= 4'hF;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], ~reset_in_n};
         probe_s1_reg <= four_probes;
         probe_s2_reg <= probe_s1_reg;
         octet_s1_reg <= octet_in;
         octet_s2_reg <= octet_s1_reg;
         bidir_s1_reg <= bidir_in;
         bidir_s2_reg <= bidir_s1_reg;
         probes_out <= probe_s2_reg;
      end
   end
   // instruction cycle divider: oscillator divided by 16, 8 or 4
   logic [3:0] div_cnt_reg, div_last;
   logic tick;
   always_comb begin
      // RULE19: divide selection
      case (div_mode)
         nmcd_div8: div_last = 4'(`NMCD_DIV8 - 1);
         // RULE20: rc oscillator divides by 4
         nmcd_div4: div_last = 4'(`NMCD_DIV4 - 1);
         default: div_last = 4'(`NMCD_DIV16 - 1);
      endcase
   end
   assign tick = (div_cnt_reg >= div_last);
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) div_cnt_reg <= 4'h0;
      else if (tick) div_cnt_reg <= 4'h0;
      else div_cnt_reg <= div_cnt_reg + 4'h1;
   end
   // external reset must stay low for three instruction cycles
   logic [1:0] rst_cnt_reg;
   logic core_rst, exec;
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) rst_cnt_reg <= 2'h0;
      else if (!rst_sync_reg[1]) rst_cnt_reg <= 2'h0;
      else if (tick && rst_cnt_reg != 2'(`NMCD_RST_CYCLES)) rst_cnt_reg <= rst_cnt_reg + 2'h1;
   end
   // RULE23: reset qualified by length
   assign core_rst = rst_sync_reg[1] && (rst_cnt_reg == 2'(`NMCD_RST_CYCLES));
   assign exec = tick && op_valid && !core_rst;
   // RULE1: program store, pages of 64 words
   logic [7:0] rom_mem [ROM_WORDS];
   logic [PC_W-1:0] page_base;
   assign page_base = {fetch_pointer[PC_W-1:6], 6'h00};
   always_ff @(posedge sys_clk) begin
      if (rom_we) rom_mem[rom_waddr] <= rom_wdata;
   end
   // RULE2: fetch pointer selects one word
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) rom_data <= 8'h00;
      else rom_data <= rom_mem[fetch_pointer];
   end
   logic [PC_W-1:0] pc_inc;
   // RULE25: wrap within pointer width
   assign pc_inc = PC_W'(fetch_pointer + 1'b1);
   // RULE3: fetch pointer update
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) fetch_pointer <= `NMCD_PC_RST;
      else if (core_rst) fetch_pointer <= `NMCD_PC_RST;
      else if (exec) begin
         case (op_code)
            nmcd_op_jump, nmcd_op_call: fetch_pointer <= op_target;
            nmcd_op_jump_page: fetch_pointer <= page_base | {4'h0, op_target[5:0]};
            nmcd_op_call_page: fetch_pointer <= {4'h2, op_target[5:0]};
            nmcd_op_ret: fetch_pointer <= stack_top;
            nmcd_op_jump_indirect: fetch_pointer <= {fetch_pointer[PC_W-1:8], rom_data};
            default: fetch_pointer <= pc_inc;
         endcase
      end
   end
   // RULE4: three-level return stack
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         stack_top <= 10'h000;
         stack_mid <= 10'h000;
         stack_bottom <= 10'h000;
      end else if (exec) begin
         // RULE26: push shifts down, pop shifts up
         if (op_code == nmcd_op_call || op_code == nmcd_op_call_page
             || op_code == nmcd_op_load_port_store_indirect) begin
            stack_top <= pc_inc;
            stack_mid <= stack_top;
            stack_bottom <= stack_mid;
         end else if (op_code == nmcd_op_ret) begin
            stack_top <= stack_mid;
            stack_mid <= stack_bottom;
         end
      end
   end
   // RULE5: data store, not cleared by reset
   logic [3:0] data_mem [`NMCD_ROWS*`NMCD_DIGITS];
   logic [5:0] mem_addr;
   logic direct_op, mem_we;
   assign direct_op = (op_code == nmcd_op_load_direct || op_code == nmcd_op_swap_direct);
   // RULE8: operand address replaces pointer
   // RULE6: row in upper bits, digit in lower
   assign mem_addr = direct_op ? op_operand[5:0] : {row_select, digit_select};
   logic [3:0] mem_rd, mem_wd;
   assign mem_rd = data_mem[mem_addr];
   logic [7:0] port_store_reg;
   always_comb begin
      mem_we = 1'b0;
      mem_wd = acc_out;
      // RULE7: digit write sources
      case (op_code)
         nmcd_op_store_mem, nmcd_op_swap_mem, nmcd_op_swap_direct: mem_we = 1'b1;
         nmcd_op_mem_from_ps: begin
            mem_we = 1'b1;
            mem_wd = op_operand[0] ? port_store_reg[7:4] : port_store_reg[3:0];
         end
         // RULE18: octet pins into digit
         nmcd_op_mem_from_port: begin
            mem_we = 1'b1;
            mem_wd = op_operand[0] ? octet_s2_reg[7:4] : octet_s2_reg[3:0];
         end
         default: mem_we = 1'b0;
      endcase
   end
   always_ff @(posedge sys_clk) begin
      if (exec && mem_we) data_mem[mem_addr] <= mem_wd;
   end
   // RULE12: adder and carry
   logic [4:0] sum;
   assign sum = {1'b0, acc_out} + {1'b0, mem_rd} + {4'h0, op_code == nmcd_op_add_carry && carry_out};
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         acc_out <= 4'h0;
         carry_out <= 1'b0;
      end else if (core_rst) begin
         acc_out <= 4'h0;
         carry_out <= 1'b0;
      end else if (exec) begin
         // RULE10: result register sources
         case (op_code)
            nmcd_op_add, nmcd_op_add_carry: begin
               acc_out <= sum[3:0];
               carry_out <= sum[4];
            end
            nmcd_op_load_mem, nmcd_op_swap_mem, nmcd_op_load_direct, nmcd_op_swap_direct: acc_out <= mem_rd;
            nmcd_op_swap_acc_serial: acc_out <= serial_in_word;
            // RULE11: nibble of port store or octet port
            nmcd_op_acc_from_ps: acc_out <= op_operand[0] ? port_store_reg[7:4] : port_store_reg[3:0];
            nmcd_op_acc_from_port: acc_out <= op_operand[0] ? octet_s2_reg[7:4] : octet_s2_reg[3:0];
            default: acc_out <= acc_out;
         endcase
      end
   end
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         row_select <= 2'h0;
         digit_select <= 4'h0;
      end else if (core_rst) begin
         row_select <= 2'h0;
         digit_select <= 4'h0;
      end else if (exec && op_code == nmcd_op_load_row) row_select <= acc_out[1:0];
      else if (exec && op_code == nmcd_op_load_digit) digit_select <= acc_out;
   end
   // RULE9: digit select to output nibble
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) nibble_out <= 4'h0;
      else if (core_rst) nibble_out <= 4'h0;
      else if (exec && op_code == nmcd_op_digit_out) nibble_out <= digit_select;
   end
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) feature_out <= 4'h0;
      else if (core_rst) feature_out <= 4'h0;
      else if (exec && op_code == nmcd_op_load_feature_reg) feature_out <= op_operand[3:0];
   end
   // serial swap hands the result to the shift register outside
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         serial_out_word <= 4'h0;
         serial_load <= 1'b0;
      end else begin
         serial_load <= exec && op_code == nmcd_op_swap_acc_serial;
         if (exec && op_code == nmcd_op_swap_acc_serial) serial_out_word <= acc_out;
      end
   end
   // RULE22: clock pin latch; reset leaves sync clock on
   logic clock_pin_latch;
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) clock_pin_latch <= 1'b1;
      else if (core_rst) clock_pin_latch <= 1'b1;
      else if (exec && op_code == nmcd_op_swap_acc_serial) clock_pin_latch <= carry_out;
   end
   // RULE13: direct level when shift bit set, gated clock when shift bit clear
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) shift_clock_pin <= 1'b0;
      else if (feature_out[`NMCD_EN_SHIFT_BIT]) shift_clock_pin <= clock_pin_latch;
      else shift_clock_pin <= clock_pin_latch && (div_cnt_reg < {1'b0, div_last[3:1]} + 4'h1);
   end
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) instr_tick <= 1'b0;
      else instr_tick <= tick;
   end
   // RULE14: host strobes from probes
   logic host_rd, host_wr, wr_prev_reg;
   assign host_rd = host_bus_opt && !probe_s2_reg[2] && !probe_s2_reg[1];
   assign host_wr = host_bus_opt && !probe_s2_reg[2] && !probe_s2_reg[3];
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) wr_prev_reg <= 1'b0;
      else wr_prev_reg <= host_wr;
   end
   // RULE16: port store sources
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) port_store_reg <= 8'h00;
      // RULE17: host write captures pins; host wins over program
      else if (host_wr && !wr_prev_reg) port_store_reg <= octet_s2_reg;
      else if (exec) begin
         case (op_code)
            nmcd_op_ps_from_acc: port_store_reg <= {op_operand[0] ? acc_out : port_store_reg[7:4],
                                                    op_operand[0] ? port_store_reg[3:0] : acc_out};
            nmcd_op_ps_from_mem: port_store_reg <= {mem_rd, acc_out};
            nmcd_op_ps_const: port_store_reg <= op_operand;
            nmcd_op_load_port_store_indirect: port_store_reg <= rom_data;
            default: port_store_reg <= port_store_reg;
         endcase
      end
   end
   // RULE21: drivers enabled by feature bit 2
   // RULE24: host read also drives the port store
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         octet_out <= 8'h00;
         octet_oe <= 1'b0;
      end else begin
         octet_out <= port_store_reg;
         octet_oe <= feature_out[`NMCD_EN_DRV_BIT] || host_rd;
      end
   end
   // RULE15: bidirectional nibble with optional ready on bit 0
   logic [3:0] bidir_reg;
   logic ready_reg;
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) bidir_reg <= 4'h0;
      else if (core_rst) bidir_reg <= 4'h0;
      else if (exec && op_code == nmcd_op_bidir_from_acc) bidir_reg <= acc_out;
   end
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) ready_reg <= 1'b0;
      // RULE24: write pulse clears ready
      else if (host_wr) ready_reg <= 1'b0;
      else if (exec && op_code == nmcd_op_bidir_from_acc) ready_reg <= acc_out[0];
   end
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) bidir_out <= 4'h0;
      else bidir_out <= {bidir_reg[3:1], (host_bus_opt && ready_opt) ? ready_reg : bidir_reg[0]};
   end
endmodule // nmcd_core

/* verilog/nmcd_cfg.svh */
`ifndef NMCD_CFG_SVH
`define NMCD_CFG_SVH
`define NMCD_PC_W 10
`define NMCD_ROM_WORDS 1024
`define NMCD_PAGE_WORDS 64
`define NMCD_PAGES 16
`define NMCD_DP_W 6
`define NMCD_ROWS 4
`define NMCD_DIGITS 16
`define NMCD_PC_RST 10'h000
`define NMCD_EN_SHIFT_BIT 0
`define NMCD_EN_DRV_BIT 2
`define NMCD_EN_SO_BIT 3
`define NMCD_CLK_MHZ 100
`define NMCD_RST_CYCLES 3
`define NMCD_DIV16 16
`define NMCD_DIV8 8
`define NMCD_DIV4 4
`endif

/* verilog/nmcd_pkg.sv */
package nmcd_pkg;
   typedef enum logic [1:0] {nmcd_div16, nmcd_div8, nmcd_div4} nmcd_div_t;
   typedef enum logic [4:0] {
      nmcd_op_nop, nmcd_op_jump, nmcd_op_jump_page, nmcd_op_call_page, nmcd_op_call, nmcd_op_ret,
      nmcd_op_jump_indirect, nmcd_op_load_port_store_indirect, nmcd_op_add, nmcd_op_add_carry,
      nmcd_op_load_mem, nmcd_op_store_mem, nmcd_op_swap_mem, nmcd_op_load_direct, nmcd_op_swap_direct,
      nmcd_op_load_row, nmcd_op_load_digit, nmcd_op_digit_out, nmcd_op_load_feature_reg,
      nmcd_op_swap_acc_serial, nmcd_op_ps_from_acc, nmcd_op_ps_from_mem, nmcd_op_ps_const,
      nmcd_op_acc_from_ps, nmcd_op_mem_from_ps, nmcd_op_acc_from_port, nmcd_op_mem_from_port,
      nmcd_op_bidir_from_acc
   } nmcd_op_t;
endpackage

/* verification/nmcd_core_monitor.sv */
`timescale 1ns/100ps
module nmcd_core_monitor
   import nmcd_pkg::*;
#(
   parameter int PC_W = 10
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic reset_in_n,
   input wire logic host_bus_opt,
   input wire logic op_valid,
   input wire nmcd_op_t op_code,
   input wire logic [PC_W-1:0] op_target,
   input wire logic [3:0] four_probes,
   input wire logic [PC_W-1:0] fetch_pointer,
   input wire logic [PC_W-1:0] stack_top,
   input wire logic [PC_W-1:0] stack_mid,
   input wire logic [3:0] acc_out,
   input wire logic [3:0] feature_out,
   input wire logic octet_oe,
   input wire logic instr_tick
);
   logic [5:0] low_cnt_reg;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   // saturates at 63, long enough for three ticks even at divide by 16
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) low_cnt_reg <= 6'h00;
      else if (reset_in_n) low_cnt_reg <= 6'h00;
      else if (low_cnt_reg != 6'h3F) low_cnt_reg <= low_cnt_reg + 6'h01;
   end
   // pin reset is synchronised, so recent low levels are kept out
   sequence exec_s(nmcd_op_t op);
      reset_in_n && $past(reset_in_n, 8) && instr_tick && $past(op_valid) && $past(op_code) == op;
   endsequence
   sequence host_read_s;
      (host_bus_opt && four_probes[2:1] == 2'b00) [*8];
   endsequence
   seq_advance_a: assert property (exec_s(nmcd_op_nop) |-> fetch_pointer == PC_W'($past(fetch_pointer) + 1))
      else $error("fetch pointer did not step by one");
   jump_target_a: assert property (exec_s(nmcd_op_jump) |-> fetch_pointer == $past(op_target))
      else $error("jump target not taken");
   call_push_a: assert property (exec_s(nmcd_op_call) |->
      stack_top == PC_W'($past(fetch_pointer) + 1) && stack_mid == $past(stack_top)) else $error("call push wrong");
   ret_pop_a: assert property (exec_s(nmcd_op_ret) |->
      fetch_pointer == $past(stack_top) && stack_top == $past(stack_mid)) else $error("return pop wrong");
   pointer_hold_a: assert property (!instr_tick && reset_in_n && $past(reset_in_n, 8) |->
      $stable(fetch_pointer)) else $error("fetch pointer moved off tick");
   drive_enable_a: assert property ($changed(feature_out[2]) && four_probes[2:1] == 2'b11 |->
      ##[1:2] octet_oe == feature_out[2]) else $error("octet drive does not follow feature bit");
   host_read_a: assert property (host_read_s |-> octet_oe)
      else $error("host read did not drive octet port");
   pin_reset_a: assert property (low_cnt_reg == 6'h3F |->
      fetch_pointer == '0 && acc_out == 4'h0 && feature_out == 4'h0) else $error("pin reset did not clear");
endmodule // nmcd_core_monitor
bind nmcd_core nmcd_core_monitor #(.PC_W(PC_W)) MON (
   .sys_clk(sys_clk), .sys_rst(sys_rst), .reset_in_n(reset_in_n), .host_bus_opt(host_bus_opt),
   .op_valid(op_valid), .op_code(op_code), .op_target(op_target), .four_probes(four_probes),
   .fetch_pointer(fetch_pointer), .stack_top(stack_top), .stack_mid(stack_mid), .acc_out(acc_out),
   .feature_out(feature_out), .octet_oe(octet_oe), .instr_tick(instr_tick)
);

/* verification/nmcd_host_model.sv */
`timescale 1ns/100ps
module nmcd_host_model (
   input wire logic sys_clk,
   input wire logic [7:0] octet_out,
   input wire logic octet_oe,
   output logic [3:0] four_probes = 4'hF,
   output logic [7:0] octet_in
);
   logic [7:0] bus_reg = 8'hFF;
   assign octet_in = octet_oe ? octet_out : bus_reg;
   task automatic host_write(input logic [7:0] data, input logic sel);
      @(posedge sys_clk) four_probes[2] <= ~sel;
      repeat (7) @(posedge sys_clk);
      bus_reg <= data;
      four_probes[3] <= 1'b0;
      repeat (40) @(posedge sys_clk);
      four_probes[3] <= 1'b1;
      repeat (10) @(posedge sys_clk);
      four_probes[2] <= 1'b1;
      // released bus shows the inverse so a stale value cannot pass
      bus_reg <= ~data;
   endtask
   task automatic host_read(output logic [7:0] data);
      @(posedge sys_clk) four_probes[2] <= 1'b0;
      repeat (7) @(posedge sys_clk);
      four_probes[1] <= 1'b0;
      repeat (40) @(posedge sys_clk);
      data = octet_in;
      four_probes[1] <= 1'b1;
      repeat (2) @(posedge sys_clk);
      four_probes[2] <= 1'b1;
   endtask
endmodule // nmcd_host_model

/* verification/nmcd_core_tb.sv */
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin fail_count++; \
   $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end
module nmcd_core_tb;
   import nmcd_pkg::*;
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic reset_in_n = 1'b1;
   logic op_valid = 1'b0;
   nmcd_op_t op_code = nmcd_op_nop;
   nmcd_div_t div_mode = nmcd_div4;
   logic [7:0] op_operand = 8'h00;
   logic [9:0] op_target = 10'h000;
   logic rom_we = 1'b0;
   logic [9:0] rom_waddr = 10'h000;
   logic [7:0] rom_wdata = 8'h00;
   logic [3:0] four_probes, acc_out, feature_out, digit_select, nibble_out;
   logic [1:0] row_select;
   logic [7:0] octet_in, rom_data, octet_out;
   logic [9:0] fetch_pointer, stack_top, stack_mid, stack_bottom;
   logic octet_oe, instr_tick, carry_out;
   int fail_count = 0;
   int check_count = 0;
   initial forever #5 sys_clk = ~sys_clk;
   nmcd_core DUT (
      .sys_clk(sys_clk), .sys_rst(sys_rst), .reset_in_n(reset_in_n), .div_mode(div_mode), .host_bus_opt(1'b1),
      .ready_opt(1'b0), .op_valid(op_valid), .op_code(op_code), .op_operand(op_operand), .op_target(op_target),
      .rom_we(rom_we), .rom_waddr(rom_waddr), .rom_wdata(rom_wdata), .serial_in_word(4'h0),
      .four_probes(four_probes), .octet_in(octet_in), .bidir_in(4'h0), .rom_data(rom_data),
      .fetch_pointer(fetch_pointer), .stack_top(stack_top), .stack_mid(stack_mid), .stack_bottom(stack_bottom),
      .acc_out(acc_out), .carry_out(carry_out), .row_select(row_select), .digit_select(digit_select),
      .nibble_out(nibble_out), .bidir_out(),
      .feature_out(feature_out), .serial_out_word(), .serial_load(), .octet_out(octet_out), .octet_oe(octet_oe),
      .shift_clock_pin(), .instr_tick(instr_tick), .probes_out()
   );
   nmcd_host_model HOST (
      .sys_clk(sys_clk), .octet_out(octet_out), .octet_oe(octet_oe), .four_probes(four_probes), .octet_in(octet_in)
   );
   task automatic final_report();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic wait_tick();
      int n;
      n = 0;
      do begin
         @(negedge sys_clk);
         n++;
      end while (instr_tick !== 1'b1 && n < 40);
      if (instr_tick !== 1'b1) begin
         fail_count++;
         $display("tick wait ran out");
         final_report();
      end
   endtask
   // op held one tick then dropped, so it can never run twice
   task automatic do_op(input nmcd_op_t code, input logic [9:0] tgt, input logic [7:0] opd);
      wait_tick();
      @(posedge sys_clk);
      op_valid <= 1'b1;
      op_code <= code;
      op_target <= tgt;
      op_operand <= opd;
      wait_tick();
      @(posedge sys_clk);
      op_valid <= 1'b0;
      @(negedge sys_clk);
   endtask
   task automatic test_divide();
      nmcd_div_t md [3] = '{nmcd_div16, nmcd_div8, nmcd_div4};
      int per [3] = '{16, 8, 4};
      int n;
      for (int i = 0; i < 3; i++) begin
         @(posedge sys_clk);
         div_mode <= md[i];
         wait_tick();
         wait_tick();
         n = 0;
         do begin
            @(negedge sys_clk);
            n++;
         end while (instr_tick !== 1'b1 && n < 40);
         `CHK("tick period", per[i], n)
         if (n >= 40) final_report();
      end
      $display("test divide done");
   endtask
   task automatic test_data();
      do_op(nmcd_op_ps_const, 10'h000, 8'h97);
      do_op(nmcd_op_acc_from_ps, 10'h000, 8'h01);
      `CHK("acc_out", 4'h9, acc_out)
      do_op(nmcd_op_load_digit, 10'h000, 8'h00);
      do_op(nmcd_op_load_row, 10'h000, 8'h00);
      `CHK("digit_select", 4'h9, digit_select)
      `CHK("row_select", 2'h1, row_select)
      do_op(nmcd_op_digit_out, 10'h000, 8'h00);
      `CHK("nibble_out", 4'h9, nibble_out)
      do_op(nmcd_op_store_mem, 10'h000, 8'h00);
      do_op(nmcd_op_acc_from_ps, 10'h000, 8'h00);
      do_op(nmcd_op_add, 10'h000, 8'h00);
      `CHK("acc_out", 4'h0, acc_out)
      `CHK("carry_out", 1'b1, carry_out)
      do_op(nmcd_op_add_carry, 10'h000, 8'h00);
      `CHK("acc_out", 4'hA, acc_out)
      do_op(nmcd_op_load_direct, 10'h000, 8'h19);
      `CHK("acc_out", 4'h9, acc_out)
      $display("test data done");
   endtask
   task automatic test_rom();
      logic [9:0] adr [2] = '{10'h3FF, 10'h040};
      logic [7:0] dat [2] = '{8'hA5, 8'h3C};
      for (int i = 0; i < 2; i++) begin
         @(posedge sys_clk);
         rom_we <= 1'b1;
         rom_waddr <= adr[i];
         rom_wdata <= dat[i];
         @(posedge sys_clk);
         rom_we <= 1'b0;
         do_op(nmcd_op_jump, adr[i], 8'h00);
         `CHK("rom_data", dat[i], rom_data)
      end
      $display("test rom done");
   endtask
   task automatic test_wrap();
      do_op(nmcd_op_jump, 10'h3FE, 8'h00);
      `CHK("fetch_pointer", 10'h3FE, fetch_pointer)
      do_op(nmcd_op_nop, 10'h000, 8'h00);
      `CHK("fetch_pointer", 10'h3FF, fetch_pointer)
      do_op(nmcd_op_nop, 10'h000, 8'h00);
      `CHK("fetch_pointer", 10'h000, fetch_pointer)
      $display("test wrap done");
   endtask
   task automatic test_stack();
      logic [9:0] tgt [4] = '{10'h200, 10'h300, 10'h010, 10'h020};
      logic [9:0] top [4] = '{10'h101, 10'h201, 10'h301, 10'h011};
      do_op(nmcd_op_jump, 10'h100, 8'h00);
      for (int i = 0; i < 4; i++) begin
         do_op(nmcd_op_call, tgt[i], 8'h00);
         `CHK("fetch_pointer", tgt[i], fetch_pointer)
         `CHK("stack_top", top[i], stack_top)
      end
      `CHK("stack_bottom", 10'h201, stack_bottom)
      do_op(nmcd_op_ret, 10'h000, 8'h00);
      `CHK("fetch_pointer", 10'h011, fetch_pointer)
      `CHK("stack_top", 10'h301, stack_top)
      $display("test stack done");
   endtask
   task automatic test_port();
      do_op(nmcd_op_ps_const, 10'h000, 8'h5A);
      do_op(nmcd_op_load_feature_reg, 10'h000, 8'h04);
      `CHK("feature_out", 4'h4, feature_out)
      `CHK("octet_oe", 1'b1, octet_oe)
      `CHK("octet_out", 8'h5A, octet_out)
      do_op(nmcd_op_load_feature_reg, 10'h000, 8'h00);
      `CHK("octet_oe", 1'b0, octet_oe)
      $display("test port done");
   endtask
   task automatic test_pin_reset();
      do_op(nmcd_op_load_feature_reg, 10'h000, 8'h0A);
      @(posedge sys_clk);
      reset_in_n <= 1'b0;
      repeat (80) @(posedge sys_clk);
      reset_in_n <= 1'b1;
      @(negedge sys_clk);
      `CHK("fetch_pointer", 10'h000, fetch_pointer)
      `CHK("feature_out", 4'h0, feature_out)
      `CHK("acc_out", 4'h0, acc_out)
      `CHK("digit_select", 4'h0, digit_select)
      do_op(nmcd_op_load_direct, 10'h000, 8'h19);
      `CHK("acc_out", 4'h9, acc_out)
      $display("test pin reset done");
   endtask
   task automatic test_host();
      logic [7:0] got;
      HOST.host_write(8'hC3, 1'b1);
      HOST.host_read(got);
      `CHK("host read", 8'hC3, got)
      HOST.host_write(8'h11, 1'b0);
      HOST.host_read(got);
      `CHK("host read", 8'hC3, got)
      $display("test host done");
   endtask
   initial begin
      repeat (20) @(posedge sys_clk);
      sys_rst <= 1'b0;
      @(negedge sys_clk);
      `CHK("fetch_pointer", 10'h000, fetch_pointer)
      test_divide();
      test_rom();
      test_wrap();
      test_stack();
      test_port();
      test_data();
      test_pin_reset();
      test_host();
      final_report();
   end
endmodule // nmcd_core_tb
